/* fcd_defs.svh */
// Fuse decoder constants: offsets, field positions, codes and timing.
// Assumes inclusion by bare name from the decoder design file.
`ifndef FCD_DEFS_SVH
`define FCD_DEFS_SVH

// Fuse byte offsets within nonvolatile storage
`define FCD_OFS_OSCILLATOR_CONFIG_FUSE      4'h2
`define FCD_OFS_SYSA        4'h5
`define FCD_OFS_SYSB        4'h6
`define FCD_OFS_APP_SECTION_END      4'h7
`define FCD_OFS_BOOT_SECTION_END     4'h8
`define FCD_OFS_LOCK        4'hA
`define FCD_OFS_LAST        4'hA

// Field positions
`define FCD_BIT_OSC_CAL_LOCK     7
`define FCD_FREQ_HI         1
`define FCD_FREQ_LO         0
`define FCD_CRC_HI          7
`define FCD_CRC_LO          6
`define FCD_PIN_HI          3
`define FCD_PIN_LO          2
`define FCD_BIT_KEEPEE      0
`define FCD_SUT_HI          2
`define FCD_SUT_LO          0

// Codes
`define FCD_FREQ_16M        2'h1
`define FCD_FREQ_20M        2'h2
`define FCD_PIN_GPIO        2'h0
`define FCD_PIN_PDP         2'h1
`define FCD_PIN_RESET       2'h2
`define FCD_OPEN_KEY        8'hC5
`define FCD_ZERO_BYTE       8'h00
`define FCD_SYSA_RESET      8'hC4

// APB register byte addresses (fuse offsets are bytes, kept as word index)
`define FCD_ADDR_OSC        12'h008
`define FCD_ADDR_SYSA       12'h014
`define FCD_ADDR_SYSB       12'h018
`define FCD_ADDR_APP_SECTION_END     12'h01C
`define FCD_ADDR_BOOT_SECTION_END    12'h020
`define FCD_ADDR_LOCK       12'h028
`define FCD_ADDR_STATUS     12'h040
`define FCD_ADDR_CTRL       12'h044

// Timing
`define FCD_BLANK_SLOW_CYC  768
`define FCD_CLK_HZ          25000000
`define FCD_MS_PER_S        1000

`endif

/* fcd_pkg.sv */
// Types shared by the fuse decoder files.
// Assumes nothing beyond a SystemVerilog compiler.
package fcd_pkg;
    // Loader states, Gray along load path
    typedef enum logic [2:0] {
        FCD_S_IDLE  = 3'b000,
        FCD_S_READ  = 3'b001,
        FCD_S_WAIT  = 3'b011,
        FCD_S_DELAY = 3'b010,
        FCD_S_DONE  = 3'b110
    } fcd_state_e;

    // Scan region selection
    typedef enum logic [1:0] {
        FCD_SCAN_FLASH   = 2'b00,
        FCD_SCAN_BOOT    = 2'b01,
        FCD_SCAN_BOOTAPP = 2'b10,
        FCD_SCAN_NONE    = 2'b11
    } fcd_scan_e;
endpackage : fcd_pkg

/* fcd_fuse_shadow.sv */
// Shadow store of fuse bytes, written by the loader.
// Assumes one clock; read data come out of a register.
`timescale 1ns/10ps
`default_nettype none
module fcd_fuse_shadow #(
    parameter int DEPTH = 16,
    parameter int AW    = 4
) (
    // Clock
    input  wire logic          clk,
    // Write side
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [7:0]    wr_data,
    // Read side
    input  wire logic [AW-1:0] rd_addr,
    output var  logic [7:0]    rd_data
);
    logic [7:0] mem_reg [DEPTH];

    // Storage write
    always_ff @(posedge clk) begin
        if (wr_en) begin
            mem_reg[wr_addr] <= wr_data;
        end
    end

    // Registered read
    always_ff @(posedge clk) begin
        rd_data <= mem_reg[rd_addr];
    end
endmodule : fcd_fuse_shadow
`default_nettype wire

/* fcd_down_timer.sv */
// Loadable down counter giving a busy level while nonzero.
// Assumes a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module fcd_down_timer #(
    parameter int W = 24
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Control
    input  wire logic         load,
    input  wire logic [W-1:0] count,
    // Status
    output var  logic         busy
);
    logic [W-1:0] cnt_reg;

    // Count down to zero, reload wins
    always_ff @(posedge clk) begin
        if (rst) begin
            cnt_reg <= '0;
        end else if (load) begin
            cnt_reg <= count;
        end else if (cnt_reg != '0) begin
            cnt_reg <= cnt_reg - W'(1);
        end
    end

    assign busy = (cnt_reg != '0);
endmodule : fcd_down_timer
`default_nettype wire

/* fcd_fuse_config_decode.sv */
// Fuse configuration decoder: loads fuse bytes at reset, decodes them
// for clock, reset, flash and program/debug port, APB register view.
// Assumes fuse storage answers a read one or more cycles after request.
//
// Our own choice: the APB slave port.
`timescale 1ns/10ps
`default_nettype none
`include "fcd_defs.svh"

// Behaviour
// - Oscillator lock fuse bit 7 copied
// - Frequency code 1=16MHz, 2=20MHz, else reserved
// - Load factory calibration for selected frequency
// - Scan region select from two-bit field
// - Reset pin: GPIO, debug port, reset
// - GPIO driver blanked 768 slow cycles
// - Keep-EEPROM bit controls erase on chip erase
// - Locked device always erases EEPROM
// - Start-up delay 0 to 64 ms
// - Application end in 256-byte blocks
// - Application end zero: rest is code
// - Boot end in 256-byte blocks, zero whole
// - Both zero: whole flash is boot
// - Open only when key equals C5
// - Locked debug port denied system bus
module fcd_fuse_config_decode #(
    parameter int          SLOW_HZ      = 32768,
    parameter int          MS_CYC       = `FCD_CLK_HZ / `FCD_MS_PER_S,
    parameter logic [23:0] FLASH_BYTES  = 24'h001000,
    parameter logic [7:0]  CAL16_FREQ   = 8'h20,
    parameter logic [7:0]  CAL16_TEMP   = 8'h04,
    parameter logic [7:0]  CAL20_FREQ   = 8'h28,
    parameter logic [7:0]  CAL20_TEMP   = 8'h05
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // APB slave
    input  wire logic        PSEL,
    input  wire logic        PENABLE,
    input  wire logic        PWRITE,
    input  wire logic [11:0] PADDR,
    input  wire logic [31:0] PWDATA,
    output logic             PREADY,
    output logic [31:0]      PRDATA,
    output logic             PSLVERR,
    // Fuse storage read port
    output logic             FUSE_RD_REQ,
    output logic [3:0]       FUSE_RD_ADDR,
    input  wire logic        FUSE_RD_VALID,
    input  wire logic [7:0]  FUSE_RD_DATA,
    // Clock controller
    output logic             OSC_CAL_LOCK,
    output logic [1:0]       OSC_FREQ_SELECT,
    output logic             OSC_RUN_20M,
    output logic [7:0]       OSC_FREQ_CAL,
    output logic [7:0]       OSC_TEMP_CAL,
    // Reset controller and pin
    output logic             RELEASE_CORE,
    output logic             PIN_IS_GPIO,
    output logic             PIN_IS_DEBUG,
    output logic             PIN_IS_RESET,
    output logic             PIN_DRIVE_ALLOW,
    // Flash controller and scanner
    output logic [1:0]       SCAN_SOURCE_SELECT,
    output logic             SCAN_ENABLE,
    output logic [23:0]      BOOT_END_ADDR,
    output logic [23:0]      APP_END_ADDR,
    input  wire logic        CHIP_ERASE,
    output logic             ERASE_EEPROM,
    // Program/debug port
    output logic             DEVICE_LOCKED,
    output logic             PDP_BUS_ALLOW
);
    localparam int BLANK_CYC = int'((`FCD_BLANK_SLOW_CYC * 64'(`FCD_CLK_HZ) + SLOW_HZ - 1) / SLOW_HZ);

    fcd_pkg::fcd_state_e state_reg;
    logic [3:0]  addr_reg;
    logic [7:0]  osc_reg, sysa_reg, sysb_reg, app_reg, boot_reg, lock_reg;
    logic        blank_start_reg;
    logic        delay_start_reg;
    logic        decoded_reg;
    logic [7:0]  shadow_rd;
    logic        blank_busy, delay_busy;
    logic [23:0] delay_cyc;
    logic        locked;
    logic        apb_write, apb_read;

    // Shadow copy of raw fuse bytes for bus readback
    fcd_fuse_shadow #(.DEPTH(16), .AW(4)) u_shadow (
        .clk     (CLK),
        .wr_en   (FUSE_RD_VALID && state_reg == fcd_pkg::FCD_S_WAIT),
        .wr_addr (addr_reg),
        .wr_data (FUSE_RD_DATA),
        .rd_addr (PADDR[5:2]),
        .rd_data (shadow_rd)
    );

    // Start-up delay: 0 ms, else 2^(code-1) ms
    always_comb begin
        if (sysb_reg[`FCD_SUT_HI:`FCD_SUT_LO] == 3'h0) begin
            delay_cyc = '0;
        end else begin
            delay_cyc = 24'(MS_CYC) << (sysb_reg[`FCD_SUT_HI:`FCD_SUT_LO] - 3'h1);
        end
    end

    fcd_down_timer #(.W(24)) u_startup (
        .clk   (CLK),
        .rst   (RESET),
        .load  (delay_start_reg),
        .count (delay_cyc),
        .busy  (delay_busy)
    );

    // Blanking runs after every reset, 768 slow-oscillator periods
    fcd_down_timer #(.W(24)) u_blank (
        .clk   (CLK),
        .rst   (RESET),
        .load  (blank_start_reg),
        .count (24'(BLANK_CYC)),
        .busy  (blank_busy)
    );

    // Loader walks every fuse offset once per reset
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_reg       <= fcd_pkg::FCD_S_IDLE;
            addr_reg        <= 4'h0;
            delay_start_reg <= 1'b0;
            blank_start_reg <= 1'b0;
            decoded_reg     <= 1'b0;
        end else begin
            delay_start_reg <= 1'b0;
            blank_start_reg <= 1'b0;
            unique case (state_reg)
                fcd_pkg::FCD_S_IDLE: begin
                    state_reg <= fcd_pkg::FCD_S_READ;
                end
                fcd_pkg::FCD_S_READ: begin
                    state_reg <= fcd_pkg::FCD_S_WAIT;
                end
                fcd_pkg::FCD_S_WAIT: begin
                    if (FUSE_RD_VALID) begin
                        if (addr_reg == `FCD_OFS_LAST) begin
                            state_reg       <= fcd_pkg::FCD_S_DELAY;
                            delay_start_reg <= 1'b1;
                            blank_start_reg <= 1'b1;
                            decoded_reg     <= 1'b1;
                        end else begin
                            addr_reg  <= addr_reg + 4'h1;
                            state_reg <= fcd_pkg::FCD_S_READ;
                        end
                    end
                end
                fcd_pkg::FCD_S_DELAY: begin
                    // Timer loads this cycle, so busy is valid next
                    if (!delay_start_reg && !delay_busy) begin
                        state_reg <= fcd_pkg::FCD_S_DONE;
                    end
                end
                fcd_pkg::FCD_S_DONE: begin
                    state_reg <= fcd_pkg::FCD_S_DONE;
                end
                default: begin
                    state_reg <= fcd_pkg::FCD_S_IDLE;
                end
            endcase
        end
    end

    // Capture decoded bytes; held until next reset, except the key byte, which APB can write while open
    always_ff @(posedge CLK) begin
        if (RESET) begin
            osc_reg  <= 8'h00;
            sysa_reg <= `FCD_SYSA_RESET;
            sysb_reg <= 8'h00;
            app_reg  <= 8'h00;
            boot_reg <= 8'h00;
            lock_reg <= 8'h00;
        end else if (state_reg == fcd_pkg::FCD_S_WAIT && FUSE_RD_VALID) begin
            unique case (addr_reg)
                `FCD_OFS_OSCILLATOR_CONFIG_FUSE:  osc_reg  <= FUSE_RD_DATA;
                `FCD_OFS_SYSA:    sysa_reg <= FUSE_RD_DATA;
                `FCD_OFS_SYSB:    sysb_reg <= FUSE_RD_DATA;
                `FCD_OFS_APP_SECTION_END:  app_reg  <= FUSE_RD_DATA;
                `FCD_OFS_BOOT_SECTION_END: boot_reg <= FUSE_RD_DATA;
                `FCD_OFS_LOCK:    lock_reg <= FUSE_RD_DATA;
                default: ;
            endcase
        end else if (apb_write && PADDR == `FCD_ADDR_LOCK && !locked) begin
            // Key byte writable; a locked part cannot unlock itself
            lock_reg <= PWDATA[7:0];
        end
    end

    // Fuse storage request
    assign FUSE_RD_REQ  = (state_reg == fcd_pkg::FCD_S_READ);
    assign FUSE_RD_ADDR = addr_reg;
    assign RELEASE_CORE = (state_reg == fcd_pkg::FCD_S_DONE);

    // Oscillator decode, inert until bytes are loaded
    always_ff @(posedge CLK) begin
        if (RESET) begin
            OSC_CAL_LOCK    <= 1'b0;
            OSC_FREQ_SELECT <= 2'h0;
            OSC_RUN_20M     <= 1'b0;
            OSC_FREQ_CAL    <= 8'h00;
            OSC_TEMP_CAL    <= 8'h00;
        end else if (decoded_reg) begin
            OSC_CAL_LOCK    <= osc_reg[`FCD_BIT_OSC_CAL_LOCK];
            OSC_FREQ_SELECT <= osc_reg[`FCD_FREQ_HI:`FCD_FREQ_LO];
            OSC_RUN_20M     <= (osc_reg[`FCD_FREQ_HI:`FCD_FREQ_LO] == `FCD_FREQ_20M);
            if (osc_reg[`FCD_FREQ_HI:`FCD_FREQ_LO] == `FCD_FREQ_16M) begin
                OSC_FREQ_CAL <= CAL16_FREQ;
                OSC_TEMP_CAL <= CAL16_TEMP;
            end else if (osc_reg[`FCD_FREQ_HI:`FCD_FREQ_LO] == `FCD_FREQ_20M) begin
                OSC_FREQ_CAL <= CAL20_FREQ;
                OSC_TEMP_CAL <= CAL20_TEMP;
            end
        end
    end

    // Pin function, scan source and section bounds
    always_ff @(posedge CLK) begin
        if (RESET) begin
            PIN_IS_GPIO        <= 1'b0;
            PIN_IS_DEBUG       <= 1'b0;
            PIN_IS_RESET       <= 1'b0;
            SCAN_SOURCE_SELECT <= fcd_pkg::FCD_SCAN_NONE;
            SCAN_ENABLE        <= 1'b0;
            BOOT_END_ADDR      <= 24'h000000;
            APP_END_ADDR       <= 24'h000000;
        end else if (decoded_reg) begin
            PIN_IS_GPIO  <= (sysa_reg[`FCD_PIN_HI:`FCD_PIN_LO] == `FCD_PIN_GPIO);
            PIN_IS_DEBUG <= (sysa_reg[`FCD_PIN_HI:`FCD_PIN_LO] == `FCD_PIN_PDP);
            PIN_IS_RESET <= (sysa_reg[`FCD_PIN_HI:`FCD_PIN_LO] == `FCD_PIN_RESET);
            SCAN_SOURCE_SELECT <= sysa_reg[`FCD_CRC_HI:`FCD_CRC_LO];
            SCAN_ENABLE <= (sysa_reg[`FCD_CRC_HI:`FCD_CRC_LO] != fcd_pkg::FCD_SCAN_NONE);
            if (boot_reg == `FCD_ZERO_BYTE) begin
                // Boot end zero: whole flash is boot, also covers both zero
                BOOT_END_ADDR <= FLASH_BYTES;
                APP_END_ADDR  <= FLASH_BYTES;
            end else begin
                BOOT_END_ADDR <= {8'h00, boot_reg, 8'h00};
                if (app_reg == `FCD_ZERO_BYTE) begin
                    APP_END_ADDR <= FLASH_BYTES;
                end else begin
                    // Above this boundary is application data
                    APP_END_ADDR <= {8'h00, app_reg, 8'h00};
                end
            end
        end
    end

    // Lock decode and erase policy
    assign locked          = (lock_reg != `FCD_OPEN_KEY) || !decoded_reg;
    assign DEVICE_LOCKED   = locked;
    assign PDP_BUS_ALLOW   = !locked;
    assign ERASE_EEPROM    = CHIP_ERASE && (locked || !sysa_reg[`FCD_BIT_KEEPEE]);
    // Driver blocked during load and blanking; no edge from pin until then
    assign PIN_DRIVE_ALLOW = PIN_IS_GPIO && !blank_busy && !blank_start_reg;

    // APB: writes take zero wait states, every read takes one extra for memory
    assign apb_write = PSEL && PENABLE && PWRITE && PREADY;
    assign apb_read  = PSEL && PENABLE && !PWRITE;
    logic rd_wait_reg;
    always_ff @(posedge CLK) begin
        if (RESET) begin
            rd_wait_reg <= 1'b0;
        end else begin
            rd_wait_reg <= apb_read && !rd_wait_reg;
        end
    end
    assign PREADY  = PWRITE ? 1'b1 : rd_wait_reg;
    assign PSLVERR = 1'b0;

    // Read mux; raw fuse bytes from shadow except the key byte from its register, status and decode live
    always_comb begin
        unique case (PADDR)
            `FCD_ADDR_OSC, `FCD_ADDR_SYSA, `FCD_ADDR_SYSB,
            `FCD_ADDR_APP_SECTION_END, `FCD_ADDR_BOOT_SECTION_END: PRDATA = {24'h000000, shadow_rd};
            `FCD_ADDR_LOCK:   PRDATA = {24'h000000, lock_reg};
            `FCD_ADDR_STATUS: PRDATA = {26'h0000000, blank_busy, delay_busy,
                                        decoded_reg, RELEASE_CORE, locked, PIN_DRIVE_ALLOW};
            `FCD_ADDR_CTRL:   PRDATA = {29'h00000000, state_reg};
            default:          PRDATA = 32'h00000000;
        endcase
    end
endmodule : fcd_fuse_config_decode
`default_nettype wire

/* fcd_fuse_config_decode_props.sv */
// Checker on the fuse decoder top ports, bound to every decoder instance.
// Assumes one clock and the synchronous active-high reset of the decoder.
`timescale 1ns/10ps
`default_nettype none
module fcd_fuse_config_decode_props #(
    parameter int         SLOW_HZ    = 32768,
    parameter logic [7:0] CAL16_FREQ = 8'h20,
    parameter logic [7:0] CAL16_TEMP = 8'h04,
    parameter logic [7:0] CAL20_FREQ = 8'h28,
    parameter logic [7:0] CAL20_TEMP = 8'h05
) (
    // Clock and reset
    input wire logic        CLK,
    input wire logic        RESET,
    // Decoded outputs and erase request
    input wire logic [1:0]  OSC_FREQ_SELECT,
    input wire logic [7:0]  OSC_FREQ_CAL,
    input wire logic [7:0]  OSC_TEMP_CAL,
    input wire logic        RELEASE_CORE,
    input wire logic        PIN_IS_GPIO,
    input wire logic        PIN_IS_DEBUG,
    input wire logic        PIN_IS_RESET,
    input wire logic        PIN_DRIVE_ALLOW,
    input wire logic [1:0]  SCAN_SOURCE_SELECT,
    input wire logic        SCAN_ENABLE,
    input wire logic [23:0] APP_END_ADDR,
    input wire logic        CHIP_ERASE,
    input wire logic        ERASE_EEPROM,
    input wire logic        DEVICE_LOCKED,
    input wire logic        PDP_BUS_ALLOW
);
    localparam int BLANK = int'((768 * 64'(25000000) + SLOW_HZ - 1) / SLOW_HZ);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RESET);
    logic [23:0] since_reg;
    // Cycles since reset left; wide enough for the full blanking span
    always_ff @(posedge CLK) begin
        if (RESET) since_reg <= 24'h000000;
        else if (since_reg != 24'hFFFFFF) since_reg <= since_reg + 24'h000001;
    end
    a_blank_span: assert property (PIN_IS_GPIO && PIN_DRIVE_ALLOW |-> since_reg >= 24'(BLANK - 1))
        else $error("pin driver enabled inside blanking span");
    a_cal_twenty: assert property (RELEASE_CORE && OSC_FREQ_SELECT == 2'h2 |-> OSC_FREQ_CAL == CAL20_FREQ && OSC_TEMP_CAL == CAL20_TEMP)
        else $error("calibration for 20 MHz wrong");
    a_cal_sixteen: assert property (RELEASE_CORE && OSC_FREQ_SELECT == 2'h1 |-> OSC_FREQ_CAL == CAL16_FREQ && OSC_TEMP_CAL == CAL16_TEMP)
        else $error("calibration for 16 MHz wrong");
    a_scan_off: assert property (RELEASE_CORE |-> SCAN_ENABLE == (SCAN_SOURCE_SELECT != 2'h3))
        else $error("scan enable disagrees with source");
    a_pin_single: assert property (RELEASE_CORE |-> $onehot0({PIN_IS_GPIO, PIN_IS_DEBUG, PIN_IS_RESET}))
        else $error("more than one pin function");
    a_erase_locked: assert property (CHIP_ERASE && DEVICE_LOCKED |-> ERASE_EEPROM)
        else $error("locked erase kept eeprom");
    a_erase_cause: assert property (!CHIP_ERASE |-> !ERASE_EEPROM)
        else $error("eeprom erase without chip erase");
    a_bus_denied: assert property (DEVICE_LOCKED |-> !PDP_BUS_ALLOW)
        else $error("locked port given bus");
    a_hold_stable: assert property (RELEASE_CORE ##1 RELEASE_CORE |-> $stable(OSC_FREQ_SELECT) && $stable(APP_END_ADDR))
        else $error("decoded value moved after release");
endmodule : fcd_fuse_config_decode_props
bind fcd_fuse_config_decode fcd_fuse_config_decode_props #(
    .SLOW_HZ(SLOW_HZ), .CAL16_FREQ(CAL16_FREQ), .CAL16_TEMP(CAL16_TEMP),
    .CAL20_FREQ(CAL20_FREQ), .CAL20_TEMP(CAL20_TEMP)
) u_props (.*);
`default_nettype wire

/* fcd_fuse_store.sv */
// Fuse storage model: answers each read request after a set lag.
// Assumes one request outstanding at a time, as the loader issues them.
`timescale 1ns/10ps
`default_nettype none
module fcd_fuse_store (
    // Clock
    input  wire logic        clk,
    // Contents and answer lag from the bench
    input  wire logic [87:0] image,
    input  wire logic [3:0]  lag,
    // Read port
    input  wire logic        rd_req,
    input  wire logic [3:0]  rd_addr,
    output var  logic        rd_valid,
    output var  logic [7:0]  rd_data
);
    logic       busy_reg;
    logic [3:0] addr_reg;
    logic [3:0] wait_reg;
    initial begin
        busy_reg = 1'h0;
        rd_valid = 1'h0;
        rd_data  = 8'h5A;
    end
    // Byte valid one cycle only; idle bus toggles so a stale byte cannot pass
    always @(posedge clk) begin
        rd_valid <= 1'h0;
        rd_data  <= ~rd_data;
        if (rd_req) begin
            busy_reg <= 1'h1;
            addr_reg <= rd_addr;
            wait_reg <= lag;
        end else if (busy_reg && wait_reg != 4'h0) begin
            wait_reg <= wait_reg - 4'h1;
        end else if (busy_reg) begin
            busy_reg <= 1'h0;
            rd_valid <= 1'h1;
            rd_data  <= image[addr_reg * 8 +: 8];
        end
    end
endmodule : fcd_fuse_store
`default_nettype wire

/* tb_fuse_config_decode.sv */
// Testbench: four fuse images, each loaded through a reset, then checked.
// Assumes the storage model and the bound checker beside the decoder.
`timescale 1ns/10ps
`default_nettype none
module tb_fuse_config_decode;
    localparam int          MS    = 4;
    localparam logic [23:0] FLASH = 24'h001000;
    localparam logic [7:0]  F16 = 8'h31, T16 = 8'h06, F20 = 8'h3C, T20 = 8'h09;
    logic        CLK, RESET, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, CHIP_ERASE;
    logic [11:0] PADDR;
    logic [31:0] PWDATA, PRDATA;
    logic        FUSE_RD_REQ, FUSE_RD_VALID, OSC_CAL_LOCK, OSC_RUN_20M, RELEASE_CORE;
    logic [3:0]  FUSE_RD_ADDR, lag;
    logic [7:0]  FUSE_RD_DATA, OSC_FREQ_CAL, OSC_TEMP_CAL;
    logic [1:0]  OSC_FREQ_SELECT, SCAN_SOURCE_SELECT;
    logic        PIN_IS_GPIO, PIN_IS_DEBUG, PIN_IS_RESET, PIN_DRIVE_ALLOW, SCAN_ENABLE;
    logic [23:0] BOOT_END_ADDR, APP_END_ADDR;
    logic        ERASE_EEPROM, DEVICE_LOCKED, PDP_BUS_ALLOW;
    logic [87:0] image;
    int          errors, checked, since;
    // Fuse images by scenario; scenario 1 sizes app end as boot plus code
    logic [7:0] osc  [4] = '{8'h82, 8'h01, 8'h03, 8'h80};
    logic [7:0] sysa [4] = '{8'hC4, 8'h01, 8'h49, 8'h8C};
    logic [7:0] sysb [4] = '{8'h00, 8'h07, 8'h01, 8'h03};
    logic [7:0] app  [4] = '{8'h00, 8'h08, 8'h00, 8'h05};
    logic [7:0] boot [4] = '{8'h00, 8'h04, 8'h02, 8'h00};
    logic [7:0] key  [4] = '{8'hC5, 8'h00, 8'hC5, 8'hC4};
    logic [3:0] ofs  [6] = '{4'h2, 4'h5, 4'h6, 4'h7, 4'h8, 4'hA};
    // Short counts: one slow tick per clock, 4 clocks per millisecond
    fcd_fuse_config_decode #(.SLOW_HZ(25000000), .MS_CYC(MS), .FLASH_BYTES(FLASH),
        .CAL16_FREQ(F16), .CAL16_TEMP(T16), .CAL20_FREQ(F20), .CAL20_TEMP(T20)) dut (.*);
    fcd_fuse_store store (.clk(CLK), .image(image), .lag(lag), .rd_req(FUSE_RD_REQ),
        .rd_addr(FUSE_RD_ADDR), .rd_valid(FUSE_RD_VALID), .rd_data(FUSE_RD_DATA));
    initial begin
        CLK = 1'h0;
        forever #20 CLK = ~CLK;
    end
    always @(posedge CLK) since <= RESET ? 0 : since + 1;
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    // One APB transfer; read data taken in the cycle whose edge sees PREADY
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        PSEL    <= 1'h1;
        PWRITE  <= wr;
        PADDR   <= a;
        PWDATA  <= wd;
        @(posedge CLK);
        PENABLE <= 1'h1;
        // Hold everything until the edge that samples PREADY high
        do begin @(posedge CLK); n++; end while (PREADY !== 1'h1 && n < 50);
        if (n >= 50) check("pready", 1'h0, 1'h1);
        rd = PRDATA;
        PSEL    <= 1'h0;
        PENABLE <= 1'h0;
        @(posedge CLK);
    endtask : apb
    task automatic run_cfg(input int k);
        logic [31:0] d;
        logic [23:0] be, ae;
        logic [7:0]  fc, tc;
        logic        lk;
        int          ms;
        lk = key[k] != 8'hC5;
        ms = sysb[k][2:0] == 3'h0 ? 0 : 1 << (sysb[k][2:0] - 1);
        be = boot[k] == 8'h00 ? FLASH : {8'h00, boot[k], 8'h00};
        ae = (boot[k] == 8'h00 || app[k] == 8'h00) ? FLASH : {8'h00, app[k], 8'h00};
        fc = osc[k][1:0] == 2'h1 ? F16 : osc[k][1:0] == 2'h2 ? F20 : 8'h00;
        tc = osc[k][1:0] == 2'h1 ? T16 : osc[k][1:0] == 2'h2 ? T20 : 8'h00;
        image <= {key[k], 8'h00, boot[k], app[k], sysb[k], sysa[k], 16'h0000, osc[k], 16'h0000};
        lag   <= k[3:0] * 4'h2;
        RESET <= 1'h1;
        repeat (16) @(posedge CLK);
        RESET <= 1'h0;
        do @(negedge CLK); while (RELEASE_CORE !== 1'h1 && since < 3000);
        check("startup", since >= ms * MS && since <= ms * MS + 150, 1'h1);
        check("cal lock", OSC_CAL_LOCK, osc[k][7]);
        check("freq", {OSC_RUN_20M, OSC_FREQ_SELECT}, {osc[k][1:0] == 2'h2, osc[k][1:0]});
        check("cal vals", {OSC_FREQ_CAL, OSC_TEMP_CAL}, {fc, tc});
        check("scan src", SCAN_SOURCE_SELECT, sysa[k][7:6]);
        check("pin fn", {PIN_IS_GPIO, PIN_IS_DEBUG, PIN_IS_RESET}, 3'h4 >> sysa[k][3:2]);
        check("boot end", BOOT_END_ADDR, be);
        check("app end", APP_END_ADDR, ae);
        check("locked", {DEVICE_LOCKED, PDP_BUS_ALLOW}, {lk, !lk});
        if (sysa[k][3:2] == 2'h0 && since < 700) check("blank", PIN_DRIVE_ALLOW, 1'h0);
        @(posedge CLK);
        CHIP_ERASE <= 1'h1;
        @(negedge CLK);
        check("erase", ERASE_EEPROM, lk || !sysa[k][0]);
        @(posedge CLK);
        CHIP_ERASE <= 1'h0;
        for (int i = 0; i < 6; i++) begin
            apb(1'h0, {6'h00, ofs[i], 2'h0}, 32'h00000000, d);
            check("fuse read", d, {24'h000000, image[ofs[i] * 8 +: 8]});
        end
        apb(1'h0, 12'h00C, 32'h00000000, d);
        check("unmapped", d, 32'h00000000);
        apb(1'h1, 12'h014, 32'h000000FF, d);
        apb(1'h0, 12'h014, 32'h00000000, d);
        check("ro fuse", d, {24'h000000, sysa[k]});
        apb(1'h1, 12'h028, 32'h0000005A, d);
        apb(1'h0, 12'h028, 32'h00000000, d);
        check("key write", d, {24'h000000, lk ? key[k] : 8'h5A});
        // Load takes up to about 100 cycles, then 768 blanking cycles
        while (since < 1000) @(posedge CLK);
        @(negedge CLK);
        if (sysa[k][3:2] == 2'h0) check("drive", PIN_DRIVE_ALLOW, 1'h1);
        @(posedge CLK);
    endtask : run_cfg
    task automatic stop_test;
        $display("Checks %0d errors %0d", checked, errors);
        if (errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : stop_test
    // Watchdog: four scenarios need about 4000 cycles
    initial begin
        repeat (20000) @(posedge CLK);
        errors++;
        stop_test();
    end
    initial begin
        errors = 0;
        checked = 0;
        since = 0;
        RESET = 1'h1;
        PSEL = 1'h0;
        PENABLE = 1'h0;
        PWRITE = 1'h0;
        PADDR = 12'h000;
        PWDATA = 32'h00000000;
        CHIP_ERASE = 1'h0;
        image = '0;
        lag = 4'h0;
        @(posedge CLK);
        for (int k = 0; k < 4; k++) run_cfg(k);
        stop_test();
    end
endmodule : tb_fuse_config_decode
`default_nettype wire
